//--- design/rbg_pkg.sv
// Summary of operation
// - device returns a 32-bit read-only status word after a readback request
// - status bits 0 to 2 echo the select code from readback command bits 27 to 29, any of 0 to 7, 0 after reset
// - status bits 3 and 4 carry bank select code, fixed at bank 1
// - bits 5 and 6 hold fixed version field; bits 7 to 15 read zero
// - bits 16 to 23 hold quadrature offset code, msb set after reset
// - bits 24 to 31 hold in-phase offset code, msb set after reset
// - 5-bit serial gain in register 1 bits 12 to 16, 1 dB steps
// - three fast attenuation pins lower gain at once, no serial rewrite
// - register 1 bit 28 scales each attenuation step to 1 dB or 2 dB
// - effective gain equals serial gain minus scaled attenuation
// - effective gain saturates at zero, never wraps
// - both offset code registers load half-scale 128 at start-up
package rbg_pkg;
    localparam int          WORD_W        = 32;
    localparam int          ADDR_W        = 5;
    localparam int          GAIN_W        = 5;
    localparam int          ATTEN_W       = 3;
    localparam int          CODE_W        = 8;
    // register select values
    localparam logic [2:0]  REG_SEL_RB    = 3'h0;
    localparam logic [2:0]  REG_SEL_1     = 3'h1;
    localparam logic [2:0]  REG_SEL_2     = 3'h2;
    localparam logic [2:0]  REG_SEL_3     = 3'h3;
    localparam logic [2:0]  REG_SEL_4     = 3'h4;
    localparam logic [2:0]  REG_SEL_5     = 3'h5;
    localparam logic [1:0]  BANK_SPI      = 2'h1;
    // readback command: low five bits pattern
    localparam logic [4:0]  RB_CMD_ADDR   = 5'h08;
    // field positions
    localparam int          ADDR_LSB      = 0;
    localparam int          REGSEL_LSB    = 0;
    localparam int          BANK_LSB      = 3;
    localparam int          VER_LSB       = 5;
    localparam int          QCODE_LSB     = 16;
    localparam int          ICODE_LSB     = 24;
    localparam int          RB_SEL_LSB    = 27;
    localparam int          GAIN_LSB      = 12;
    localparam int          MULT_BIT      = 28;
    // arbitrary neutral value
    localparam logic [1:0]  VERSION_FIELD = 2'h2;
    // reset values
    localparam logic [7:0]  CODE_RESET    = 8'h80;
    localparam logic [31:0] REG1_RESET    = 32'h0001_1001;
    localparam logic [31:0] REG2_RESET    = 32'h31E0_200A;
    localparam logic [31:0] REG3_RESET    = 32'h4000_000B;
    localparam logic [31:0] REG4_RESET    = 32'h0000_000C;
    localparam logic [31:0] REG5_RESET    = 32'h0000_AAAD;
    localparam logic [2:0]  REG2_ICODE_LSB = 3'h6;
    localparam int          IDAC_LSB      = 6;
    localparam int          QDAC_LSB      = 14;
endpackage : rbg_pkg

//--- design/rbg_gain_word.sv
`timescale 1ns/1ns
module rbg_gain_word
    import rbg_pkg::*;
(
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic [GAIN_W-1:0]  serial_gain_i,
    input  wire logic               step_double_i,
    input  wire logic [ATTEN_W-1:0] atten_i,
    output logic      [GAIN_W-1:0]  baseband_gain_word_o
);
    // -----------------------------------------------
    // effective gain
    // -----------------------------------------------
    wire logic [GAIN_W:0] scaled_atten = step_double_i ? {2'h0, atten_i, 1'b0}
                                                       : {3'h0, atten_i};
    wire logic [GAIN_W:0] diff         = {1'b0, serial_gain_i} - scaled_atten;
    wire logic [GAIN_W-1:0] next_gain  = diff[GAIN_W] ? '0 : diff[GAIN_W-1:0];

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            baseband_gain_word_o <= '0;
        end else begin
            baseband_gain_word_o <= next_gain;
        end
    end
endmodule : rbg_gain_word

//--- design/rbg_readback_ctrl.sv
`timescale 1ns/1ns
module rbg_readback_ctrl
    import rbg_pkg::*;
(
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               spi_clk_i,
    input  wire logic               spi_data_i,
    input  wire logic               spi_strobe_i,
    input  wire logic               fast_atten_pin_msb_i,
    input  wire logic               fast_atten_pin_mid_i,
    input  wire logic               fast_atten_pin_lsb_i,
    output logic                    spi_rdata_o,
    output logic [GAIN_W-1:0]       baseband_gain_word_o,
    output logic [CODE_W-1:0]       inphase_offset_code_o,
    output logic [CODE_W-1:0]       quad_offset_code_o,
    output logic [WORD_W-1:0]       bias_trim_setup_o
);
    // -----------------------------------------------
    // pin synchronisers
    // -----------------------------------------------
    logic [5:0] sync_a;
    logic [5:0] sync_b;
    logic       clk_d;
    logic       strobe_d;
    wire  logic [5:0] raw_in = {fast_atten_pin_msb_i, fast_atten_pin_mid_i, fast_atten_pin_lsb_i,
                                spi_strobe_i, spi_data_i, spi_clk_i};

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= raw_in;
            sync_b <= sync_a;
        end
    end

    wire logic s_clk    = sync_b[0];
    wire logic s_data   = sync_b[1];
    wire logic s_strobe = sync_b[2];
    wire logic [ATTEN_W-1:0] s_atten = sync_b[5:3];
    wire logic clk_rise = s_clk & ~clk_d;
    wire logic clk_fall = ~s_clk & clk_d;
    wire logic latch    = s_strobe & ~strobe_d;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            clk_d    <= 1'b0;
            strobe_d <= 1'b0;
        end else begin
            clk_d    <= s_clk;
            strobe_d <= s_strobe;
        end
    end

    // -----------------------------------------------
    // shift in, bit 0 first
    // -----------------------------------------------
    logic [WORD_W-1:0] shift_in;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            shift_in <= '0;
        end else if (clk_rise) begin
            shift_in <= {s_data, shift_in[WORD_W-1:1]};
        end
    end

    // -----------------------------------------------
    // register file
    // -----------------------------------------------
    logic [WORD_W-1:0] reg1;
    logic [WORD_W-1:0] reg2;
    logic [WORD_W-1:0] reg3;
    logic [WORD_W-1:0] reg4;
    logic [WORD_W-1:0] reg5;
    logic [2:0]        rb_sel;
    logic              rb_pending;
    logic              rb_load;

    wire logic [2:0] in_sel  = shift_in[2:0];
    wire logic       in_spi  = shift_in[4:3] == BANK_SPI;
    // only bits 0 to 26 are matched; stray bits in 5 to 26 make it a write to select 0, which changes no register
    wire logic       is_rb   = latch && shift_in[ADDR_W-1:0] == RB_CMD_ADDR
                               && shift_in[RB_SEL_LSB-1:ADDR_W] == '0;
    wire logic       is_wr   = latch && in_spi && !is_rb;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg1 <= REG1_RESET;
            reg2 <= REG2_RESET;
            reg3 <= REG3_RESET;
            reg4 <= REG4_RESET;
            reg5 <= REG5_RESET;
        end else if (is_wr) begin
            case (in_sel)
                REG_SEL_1: reg1 <= shift_in;
                REG_SEL_2: reg2 <= shift_in;
                REG_SEL_3: reg3 <= shift_in;
                REG_SEL_4: reg4 <= shift_in;
                REG_SEL_5: reg5 <= shift_in;
                default:   reg1 <= reg1;
            endcase
        end
    end

    // offset codes follow the manual dac fields of register 2; msb set at reset
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            inphase_offset_code_o <= CODE_RESET;
            quad_offset_code_o    <= CODE_RESET;
        end else begin
            inphase_offset_code_o <= reg2[IDAC_LSB +: CODE_W];
            quad_offset_code_o    <= reg2[QDAC_LSB +: CODE_W];
        end
    end

    // -----------------------------------------------
    // status word and readback shifter
    // -----------------------------------------------
    wire logic [WORD_W-1:0] status_word = {inphase_offset_code_o,
                                           quad_offset_code_o,
                                           9'h000, VERSION_FIELD,
                                           BANK_SPI,
                                           rb_sel};
    logic [WORD_W-1:0] shift_out;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rb_sel     <= REG_SEL_RB;
            rb_pending <= 1'b0;
        end else if (is_rb) begin
            rb_sel     <= shift_in[RB_SEL_LSB +: 3];
            rb_pending <= 1'b1;
        end else if (latch) begin
            rb_pending <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rb_load <= 1'b0;
        end else begin
            rb_load <= is_rb;
        end
    end

    // load one cycle after the command so rb_sel already holds the new select;
    // a bit counter is not needed, zeros shift in behind the last bit
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            shift_out   <= '0;
            spi_rdata_o <= 1'b0;
        end else if (rb_load) begin
            shift_out   <= status_word;
        end else if (rb_pending && clk_fall) begin
            spi_rdata_o <= shift_out[0];
            shift_out   <= {1'b0, shift_out[WORD_W-1:1]};
        end
    end

    assign bias_trim_setup_o = reg5;

    // -----------------------------------------------
    // gain
    // -----------------------------------------------
    rbg_gain_word u_gain (
        .clk_i                (clk_i),
        .rst_i                (rst_i),
        .serial_gain_i        (reg1[GAIN_LSB +: GAIN_W]),
        .step_double_i        (reg1[MULT_BIT]),
        .atten_i              (s_atten),
        .baseband_gain_word_o (baseband_gain_word_o)
    );
endmodule : rbg_readback_ctrl

//--- verification/rbg_checker.sv
`timescale 1ns/1ns
module rbg_checker import rbg_pkg::*; (
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              spi_clk_i,
    input wire logic              spi_strobe_i,
    input wire logic              fast_atten_pin_msb_i,
    input wire logic              fast_atten_pin_mid_i,
    input wire logic              fast_atten_pin_lsb_i,
    input wire logic              spi_rdata_o,
    input wire logic [GAIN_W-1:0] baseband_gain_word_o,
    input wire logic [CODE_W-1:0] inphase_offset_code_o,
    input wire logic [CODE_W-1:0] quad_offset_code_o,
    input wire logic [WORD_W-1:0] bias_trim_setup_o);
    // ----
    // port checks
    // ----
    wire logic [2:0] atten = {fast_atten_pin_msb_i, fast_atten_pin_mid_i, fast_atten_pin_lsb_i};
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    i_reset_a: assert property ($fell(rst_i) |-> inphase_offset_code_o == CODE_RESET)
        else $error("i code not half scale");
    q_reset_a: assert property ($fell(rst_i) |-> quad_offset_code_o == CODE_RESET)
        else $error("q code not half scale");
    out_reset_a: assert property ($fell(rst_i) |-> !spi_rdata_o && bias_trim_setup_o == REG5_RESET)
        else $error("outputs wrong after reset");
    // 8 quiet cycles outlast the strobe and pin synchronisers
    gain_hold_a: assert property ((!spi_strobe_i && $stable(atten))[*8] |-> $stable(baseband_gain_word_o))
        else $error("gain moved without cause");
    i_hold_a: assert property (!spi_strobe_i [*8] |-> $stable(inphase_offset_code_o))
        else $error("i code moved without write");
    q_hold_a: assert property (!spi_strobe_i [*8] |-> $stable(quad_offset_code_o))
        else $error("q code moved without write");
    bias_hold_a: assert property (!spi_strobe_i [*8] |-> $stable(bias_trim_setup_o))
        else $error("register 5 moved without write");
    rdata_hold_a: assert property (spi_clk_i [*4] |-> $stable(spi_rdata_o))
        else $error("read data moved in high phase");
endmodule : rbg_checker
bind rbg_readback_ctrl rbg_checker u_chk (
    .clk_i                 (clk_i),
    .rst_i                 (rst_i),
    .spi_clk_i             (spi_clk_i),
    .spi_strobe_i          (spi_strobe_i),
    .fast_atten_pin_msb_i  (fast_atten_pin_msb_i),
    .fast_atten_pin_mid_i  (fast_atten_pin_mid_i),
    .fast_atten_pin_lsb_i  (fast_atten_pin_lsb_i),
    .spi_rdata_o           (spi_rdata_o),
    .baseband_gain_word_o  (baseband_gain_word_o),
    .inphase_offset_code_o (inphase_offset_code_o),
    .quad_offset_code_o    (quad_offset_code_o),
    .bias_trim_setup_o     (bias_trim_setup_o)
);

//--- verification/rbg_host_model.sv
`timescale 1ns/1ns
module rbg_host_model (
    output logic      spi_clk_o = 1'b0,
    output logic      spi_data_o = 1'b0,
    output logic      spi_strobe_o = 1'b0,
    input  wire logic spi_rdata_i);
    // ----
    // serial host, clock idles low between frames
    // ----
    task automatic xfer(input logic [31:0] w, output logic [31:0] r);
        for (int i = 0; i < 32; i++) begin
            spi_data_o = w[i];
            #160 spi_clk_o = 1'b1;
            if (i > 0) r[i - 1] = spi_rdata_i;
            #160 spi_clk_o = 1'b0;
        end
        #160 r[31] = spi_rdata_i;
        spi_strobe_o = 1'b1;
        #160 spi_strobe_o = 1'b0;
        // released line inverted so a stale bit cannot pass
        spi_data_o = ~spi_data_o;
        #200;
    endtask : xfer
endmodule : rbg_host_model

//--- verification/readback_and_pga_gain_control_tb_top.sv
`timescale 1ns/1ns
module readback_and_pga_gain_control_tb_top import rbg_pkg::*;;
    // ----
    // scenarios
    // ----
    logic                   clk_i = 1'b0, rst_i = 1'b1;
    logic [2:0]             pins = 3'h0;
    logic [31:0]            rd;
    wire logic              sclk, sdat, stb, rdata;
    wire logic [GAIN_W-1:0] gain;
    wire logic [CODE_W-1:0] icode, qcode;
    wire logic [WORD_W-1:0] bias;
    int                     error_cnt = 0, samples_checked = 0;
    initial forever #20 clk_i = ~clk_i;
    rbg_readback_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .spi_clk_i(sclk), .spi_data_i(sdat), .spi_strobe_i(stb),
        .fast_atten_pin_msb_i(pins[2]), .fast_atten_pin_mid_i(pins[1]), .fast_atten_pin_lsb_i(pins[0]),
        .spi_rdata_o(rdata), .baseband_gain_word_o(gain), .inphase_offset_code_o(icode),
        .quad_offset_code_o(qcode), .bias_trim_setup_o(bias));
    rbg_host_model hm (.spi_clk_o(sclk), .spi_data_o(sdat), .spi_strobe_o(stb), .spi_rdata_i(rdata));
    task automatic check(input string what, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) $display("Error %s expected %h seen %h", what, exp, seen);
        if (seen !== exp) error_cnt++;
    endtask : check
    task automatic test_done;
        $display("checked %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done
    task automatic t_regs;
        check("icode", icode, 8'h80);
        check("qcode", qcode, 8'h80);
        hm.xfer(32'hA | 32'h5A << IDAC_LSB | 32'hC3 << QDAC_LSB, rd);
        check("icode", icode, 8'h5A);
        check("qcode", qcode, 8'hC3);
        hm.xfer(32'h2 | 32'h11 << IDAC_LSB, rd); // bank bits 00 must be ignored
        hm.xfer(32'(RB_CMD_ADDR) | 32'h2 << RB_SEL_LSB, rd);
        hm.xfer(32'h0, rd);
        check("status", rd, {8'h5A, 8'hC3, 9'h000, VERSION_FIELD, BANK_SPI, 3'h2});
        hm.xfer(32'h0000ABCD, rd);
        check("reg5", bias, 32'h0000ABCD);
    endtask : t_regs
    task automatic t_gain;
        for (int g = 10; g <= 24; g += 7) for (int m = 0; m < 2; m++) begin
            hm.xfer(32'h9 | 32'(g) << GAIN_LSB | 32'(m) << MULT_BIT, rd);
            for (int a = 0; a < 8; a++) begin
                @(posedge clk_i) #2 pins = a[2:0];
                repeat (6) @(posedge clk_i);
                #2 check("gain", gain, g > a << m ? g - (a << m) : 0);
            end
        end
    endtask : t_gain
    initial begin
        #400000 error_cnt++;
        test_done();
    end
    initial begin
        repeat (6) @(posedge clk_i);
        #2 rst_i = 1'b0;
        repeat (4) @(posedge clk_i);
        #2 t_regs();
        t_gain();
        test_done();
    end
endmodule : readback_and_pga_gain_control_tb_top
